// ==== logic/mpf_pin_select.sv ====
`timescale 1ns/1ps
`default_nettype none

module mpf_pin_select (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // control port
  input  wire mpf_pkg::mpf_req_t req,
  output logic [7:0]             rdata,
  // multipurpose pin levels
  input  wire logic              serial_out0_multipurpose_pin_in,
  input  wire logic              mic_pair_a_multipurpose_pin_in,
  input  wire logic              mic_pair_b_multipurpose_pin_in,
  // serial output pin drive
  input  wire logic              serial_out0_data,
  output logic                   serial_out0_multipurpose_pin_out,
  output logic                   serial_out0_multipurpose_pin_oe,
  // microphone data
  output logic                   mic01_data,
  output logic                   mic23_data,
  output logic                   mic01_en,
  output logic                   mic23_en,
  // converter controls
  output logic [3:0]             adc_mute,
  output logic [1:0]             dac_mute,
  output logic                   bypass_en,
  output logic                   vol_up,
  output logic                   vol_dn
);
  import mpf_pkg::*;

  logic [7:0] serial_out0_pin_function_q;
  logic [7:0] mic_pair_a_pin_function_q;
  logic [7:0] mic_pair_b_pin_function_q;
  logic [4:0] serial_out0_pin_code;
  logic [4:0] mic_pair_a_pin_code;
  logic [4:0] mic_pair_b_pin_code;
  mpf_ctl_t   ctl_s;
  mpf_ctl_t   ctl_a;
  mpf_ctl_t   ctl_b;
  mpf_ctl_t   ctl_d;

  // function decode of one pin; reserved codes give nothing
  function automatic mpf_ctl_t mpf_decode(input logic [4:0] code, input logic lvl);
    mpf_ctl_t c;
    c = '0;
    unique case (code)
      MPF_C_MADC0:   c.adc_mute = {3'b000, lvl};
      MPF_C_MADC1:   c.adc_mute = {2'b00, lvl, 1'b0};
      MPF_C_MADC2:   c.adc_mute = {1'b0, lvl, 2'b00};
      MPF_C_MADC3:   c.adc_mute = {lvl, 3'b000};
      MPF_C_MADC01:  c.adc_mute = {2'b00, lvl, lvl};
      MPF_C_MADC23:  c.adc_mute = {lvl, lvl, 2'b00};
      MPF_C_MADCALL: c.adc_mute = {4{lvl}};
      MPF_C_MDAC0:   c.dac_mute = {1'b0, lvl};
      MPF_C_MDAC1:   c.dac_mute = {lvl, 1'b0};
      MPF_C_MDACALL: c.dac_mute = {2{lvl}};
      MPF_C_BYPASS:  c.bypass = lvl;
      MPF_C_VOLUP:   c.vol_up = lvl;
      MPF_C_VOLDN:   c.vol_dn = lvl;
      default:       c = '0;
    endcase
    return c;
  endfunction

  // selector registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out0_pin_function_q <= MPF_RST_SOUT0;
      mic_pair_a_pin_function_q  <= MPF_RST_MICA;
      mic_pair_b_pin_function_q  <= MPF_RST_MICB;
    end else if (req.wr) begin
      if (req.addr == MPF_OFS_SOUT0) begin
        serial_out0_pin_function_q <= req.wdata;
      end
      if (req.addr == MPF_OFS_MICA) begin
        mic_pair_a_pin_function_q <= req.wdata;
      end
      if (req.addr == MPF_OFS_MICB) begin
        mic_pair_b_pin_function_q <= req.wdata;
      end
    end
  end

  // read data register, unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        MPF_OFS_SOUT0: rdata <= serial_out0_pin_function_q;
        MPF_OFS_MICA:  rdata <= mic_pair_a_pin_function_q;
        MPF_OFS_MICB:  rdata <= mic_pair_b_pin_function_q;
        default:       rdata <= 8'h00;
      endcase
    end
  end

  assign serial_out0_pin_code = serial_out0_pin_function_q[MPF_CODE_MSB:0];
  assign mic_pair_a_pin_code  = mic_pair_a_pin_function_q[MPF_CODE_MSB:0];
  assign mic_pair_b_pin_code  = mic_pair_b_pin_function_q[MPF_CODE_MSB:0];

  // level controls from all three pins, merged
  always_comb begin
    ctl_s = mpf_decode(serial_out0_pin_code, serial_out0_multipurpose_pin_in);
    ctl_a = mpf_decode(mic_pair_a_pin_code, mic_pair_a_multipurpose_pin_in);
    ctl_b = mpf_decode(mic_pair_b_pin_code, mic_pair_b_multipurpose_pin_in);
    ctl_d = ctl_s | ctl_a | ctl_b;
  end

  // registered converter control outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_mute  <= 4'h0;
      dac_mute  <= 2'h0;
      bypass_en <= 1'b0;
      vol_up    <= 1'b0;
      vol_dn    <= 1'b0;
    end else begin
      adc_mute  <= ctl_d.adc_mute;
      dac_mute  <= ctl_d.dac_mute;
      bypass_en <= ctl_d.bypass;
      vol_up    <= ctl_d.vol_up;
      vol_dn    <= ctl_d.vol_dn;
    end
  end

  // primary pin functions
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out0_multipurpose_pin_out <= 1'b0;
      serial_out0_multipurpose_pin_oe  <= 1'b0;
      mic01_data                       <= 1'b0;
      mic23_data                       <= 1'b0;
      mic01_en                         <= 1'b0;
      mic23_en                         <= 1'b0;
    end else begin
      serial_out0_multipurpose_pin_oe  <= (serial_out0_pin_code == MPF_C_PRIMARY);
      serial_out0_multipurpose_pin_out <= (serial_out0_pin_code == MPF_C_PRIMARY)
                                          & serial_out0_data;
      mic01_en   <= (mic_pair_a_pin_code == MPF_C_PRIMARY);
      mic01_data <= (mic_pair_a_pin_code == MPF_C_PRIMARY) & mic_pair_a_multipurpose_pin_in;
      mic23_en   <= (mic_pair_b_pin_code == MPF_C_PRIMARY);
      mic23_data <= (mic_pair_b_pin_code == MPF_C_PRIMARY) & mic_pair_b_multipurpose_pin_in;
    end
  end

  property p_sout_oe;
    @(posedge clk) disable iff (!rst_n)
      ##1 serial_out0_multipurpose_pin_oe == ($past(serial_out0_pin_code) == 5'h00);
  endproperty
  a_sout_oe: assert property (p_sout_oe) else $error("serial pin enable wrong");

  property p_mic01;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_a_pin_code == 5'h00)
      |=> mic01_en && (mic01_data == $past(mic_pair_a_multipurpose_pin_in));
  endproperty
  a_mic01: assert property (p_mic01) else $error("mic pair a not routed");

  property p_mic23;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_b_pin_code == 5'h00)
      |=> mic23_en && (mic23_data == $past(mic_pair_b_multipurpose_pin_in));
  endproperty
  a_mic23: assert property (p_mic23) else $error("mic pair b not routed");

  property p_mute_all;
    @(posedge clk) disable iff (!rst_n)
      (serial_out0_pin_code == 5'h07 && serial_out0_multipurpose_pin_in) |=> adc_mute == 4'hf;
  endproperty
  a_mute_all: assert property (p_mute_all) else $error("mute all missed");

  property p_dac_only;
    @(posedge clk) disable iff (!rst_n)
      (ctl_d.adc_mute == 4'h0 && mic_pair_a_pin_code == 5'h0a && mic_pair_a_multipurpose_pin_in)
      |=> dac_mute == 2'h3 && adc_mute == 4'h0;
  endproperty
  a_dac_only: assert property (p_dac_only) else $error("dac mute wrong");

  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_b_pin_code == 5'h0f && mic_pair_b_multipurpose_pin_in) |=> bypass_en;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not enabled");

  property p_vol;
    @(posedge clk) disable iff (!rst_n)
      (serial_out0_pin_code == 5'h10 && serial_out0_multipurpose_pin_in) |=> vol_up;
  endproperty
  a_vol: assert property (p_vol) else $error("volume up missed");

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      (serial_out0_pin_code == 5'h0c && mic_pair_a_pin_code == 5'h12 && mic_pair_b_pin_code == 5'h1f)
      |=> adc_mute == 4'h0 && dac_mute == 2'h0 && !bypass_en && !vol_up && !vol_dn;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");

  property p_level;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_a_pin_code == 5'h11 && $stable(mic_pair_a_pin_code)
       && $past(serial_out0_pin_code) != 5'h11 && $past(mic_pair_b_pin_code) != 5'h11)
      |-> vol_dn == $past(mic_pair_a_multipurpose_pin_in);
  endproperty
  a_level: assert property (p_level) else $error("level follow wrong");

  property p_rst_sout;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> serial_out0_pin_function_q == MPF_RST_SOUT0;
  endproperty
  a_rst_sout: assert property (p_rst_sout) else $error("serial selector reset wrong");

  property p_rst_mica;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> mic_pair_a_pin_function_q == MPF_RST_MICA;
  endproperty
  a_rst_mica: assert property (p_rst_mica) else $error("mic a selector reset wrong");

  property p_rst_micb;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> mic_pair_b_pin_function_q == MPF_RST_MICB;
  endproperty
  a_rst_micb: assert property (p_rst_micb) else $error("mic b selector reset wrong");

  property p_sout_off;
    @(posedge clk) disable iff (!rst_n)
      (serial_out0_pin_code != 5'h00)
      |=> !serial_out0_multipurpose_pin_oe && !serial_out0_multipurpose_pin_out;
  endproperty
  a_sout_off: assert property (p_sout_off) else $error("serial pin driven off mode");

  property p_sout_data;
    @(posedge clk) disable iff (!rst_n)
      (serial_out0_pin_code == 5'h00)
      |=> serial_out0_multipurpose_pin_out == $past(serial_out0_data);
  endproperty
  a_sout_data: assert property (p_sout_data) else $error("serial data not on pin");

  property p_wr_sout;
    @(posedge clk) disable iff (!rst_n)
      (req.wr && req.addr == MPF_OFS_SOUT0)
      |=> serial_out0_pin_function_q == $past(req.wdata);
  endproperty
  a_wr_sout: assert property (p_wr_sout) else $error("serial selector write lost");

  property p_rd_sout;
    @(posedge clk) disable iff (!rst_n)
      (req.rd && req.addr == MPF_OFS_SOUT0) |=> rdata == $past(serial_out0_pin_function_q);
  endproperty
  a_rd_sout: assert property (p_rd_sout) else $error("serial selector read wrong");

  property p_mic01_off;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_a_pin_code != 5'h00) |=> !mic01_en && !mic01_data;
  endproperty
  a_mic01_off: assert property (p_mic01_off) else $error("mic pair a routed off mode");

  property p_mic23_off;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_b_pin_code != 5'h00) |=> !mic23_en && !mic23_data;
  endproperty
  a_mic23_off: assert property (p_mic23_off) else $error("mic pair b routed off mode");

  property p_adc2;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_b_pin_code == 5'h03 && mic_pair_b_multipurpose_pin_in) |=> adc_mute[2];
  endproperty
  a_adc2: assert property (p_adc2) else $error("adc 2 mute missed");

  property p_adc23;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_a_pin_code == 5'h06 && mic_pair_a_multipurpose_pin_in)
      |=> adc_mute[3:2] == 2'b11;
  endproperty
  a_adc23: assert property (p_adc23) else $error("adc 2 and 3 mute missed");

  property p_dac0;
    @(posedge clk) disable iff (!rst_n)
      (serial_out0_pin_code == 5'h08 && serial_out0_multipurpose_pin_in) |=> dac_mute[0];
  endproperty
  a_dac0: assert property (p_dac0) else $error("dac 0 mute missed");

  property p_vol_dn;
    @(posedge clk) disable iff (!rst_n)
      (mic_pair_b_pin_code == 5'h11 && mic_pair_b_multipurpose_pin_in) |=> vol_dn;
  endproperty
  a_vol_dn: assert property (p_vol_dn) else $error("volume down missed");

  property p_quiet;
    @(posedge clk) disable iff (!rst_n)
      (!serial_out0_multipurpose_pin_in && !mic_pair_a_multipurpose_pin_in
       && !mic_pair_b_multipurpose_pin_in)
      |=> adc_mute == 4'h0 && dac_mute == 2'h0 && !bypass_en && !vol_up && !vol_dn;
  endproperty
  a_quiet: assert property (p_quiet) else $error("control acted on low pins");

endmodule // mpf_pin_select

`default_nettype wire

// ==== logic/mpf_pkg.sv ====
package mpf_pkg;

  // register offsets on the control port
  localparam logic [7:0] MPF_OFS_SOUT0 = 8'h39;
  localparam logic [7:0] MPF_OFS_MICA  = 8'h3c;
  localparam logic [7:0] MPF_OFS_MICB  = 8'h3d;

  // reset values
  localparam logic [7:0] MPF_RST_SOUT0 = 8'h10;
  localparam logic [7:0] MPF_RST_MICA  = 8'h00;
  localparam logic [7:0] MPF_RST_MICB  = 8'h00;

  // field layout
  localparam int         MPF_CODE_MSB  = 4;
  localparam int         MPF_CODE_W    = 5;

  // function codes
  localparam logic [4:0] MPF_C_PRIMARY = 5'h00;
  localparam logic [4:0] MPF_C_MADC0   = 5'h01;
  localparam logic [4:0] MPF_C_MADC1   = 5'h02;
  localparam logic [4:0] MPF_C_MADC2   = 5'h03;
  localparam logic [4:0] MPF_C_MADC3   = 5'h04;
  localparam logic [4:0] MPF_C_MADC01  = 5'h05;
  localparam logic [4:0] MPF_C_MADC23  = 5'h06;
  localparam logic [4:0] MPF_C_MADCALL = 5'h07;
  localparam logic [4:0] MPF_C_MDAC0   = 5'h08;
  localparam logic [4:0] MPF_C_MDAC1   = 5'h09;
  localparam logic [4:0] MPF_C_MDACALL = 5'h0a;
  localparam logic [4:0] MPF_C_BYPASS  = 5'h0f;
  localparam logic [4:0] MPF_C_VOLUP   = 5'h10;
  localparam logic [4:0] MPF_C_VOLDN   = 5'h11;

  // register write/read request on the control port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mpf_req_t;

  // control levels decoded from one pin
  typedef struct packed {
    logic [3:0] adc_mute;
    logic [1:0] dac_mute;
    logic       bypass;
    logic       vol_up;
    logic       vol_dn;
  } mpf_ctl_t;

endpackage

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import mpf_pkg::*;

  // decoded control per code: adc_mute, dac_mute, bypass, up, down
  localparam logic [8:0] dec_tab [18] = '{9'h000, 9'h020, 9'h040, 9'h080, 9'h100, 9'h060,
    9'h180, 9'h1e0, 9'h008, 9'h010, 9'h018, 9'h000, 9'h000, 9'h000, 9'h000, 9'h004,
    9'h002, 9'h001};

  logic        clk;
  logic        rst_n;
  logic        sd;
  mpf_req_t    req;
  logic [2:0]  lvl;
  logic [4:0]  codes [3];
  logic [7:0]  rdata;
  wire  [14:0] outs;
  int          error_cnt;
  int          total_checks;

  mpf_pin_select uut (
    .clk                              (clk),
    .rst_n                            (rst_n),
    .req                              (req),
    .rdata                            (rdata),
    .serial_out0_multipurpose_pin_in  (lvl[0]),
    .mic_pair_a_multipurpose_pin_in   (lvl[1]),
    .mic_pair_b_multipurpose_pin_in   (lvl[2]),
    .serial_out0_data                 (sd),
    .serial_out0_multipurpose_pin_out (outs[13]),
    .serial_out0_multipurpose_pin_oe  (outs[14]),
    .mic01_en                         (outs[12]),
    .mic23_en                         (outs[11]),
    .mic01_data                       (outs[10]),
    .mic23_data                       (outs[9]),
    .adc_mute                         (outs[8:5]),
    .dac_mute                         (outs[4:3]),
    .bypass_en                        (outs[2]),
    .vol_up                           (outs[1]),
    .vol_dn                           (outs[0])
  );

  // expected pin outputs from the programmed codes and pin levels
  function automatic logic [14:0] exp_outs();
    logic [8:0] c;
    c = '0;
    for (int i = 0; i < 3; i++) begin
      if (lvl[i] && codes[i] < 5'h12) begin
        c = c | dec_tab[codes[i]];
      end
    end
    return {codes[0] == 5'h00, codes[0] == 5'h00 && sd, codes[1] == 5'h00,
            codes[2] == 5'h00, codes[1] == 5'h00 && lvl[1], codes[2] == 5'h00 && lvl[2], c};
  endfunction

  task automatic chk_pins();
    total_checks++;
    if (outs !== exp_outs()) begin
      error_cnt++;
      $display("[ERR] %0t pins got %h exp %h", $time, outs, exp_outs());
    end
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t rdata got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    chk_byte(rdata, e);
  endtask

  task automatic cfg(input logic [4:0] c0, input logic [4:0] c1, input logic [4:0] c2);
    wreg(8'h39, {3'h0, c0});
    wreg(8'h3c, {3'h0, c1});
    wreg(8'h3d, {3'h0, c2});
    codes = '{c0, c1, c2};
  endtask

  // drive pin levels, let them and any new code settle, then compare
  task automatic look(input logic [2:0] l);
    lvl = l;
    sd = l[0];
    repeat (2) @(negedge clk);
    chk_pins();
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #50us;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    lvl = 3'b111;
    sd = 1'b0;
    codes = '{5'h10, 5'h00, 5'h00};
    error_cnt = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    rchk(8'h39, 8'h10);
    rchk(8'h3c, 8'h00);
    rchk(8'h3d, 8'h00);
    rchk(8'h3a, 8'h00);
    look(3'b111);
    look(3'b000);
    // codes 00 to 11 on each pin, the other two parked on a reserved code
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 18; k++) begin
        cfg(p == 0 ? 5'(k) : 5'h0b, p == 1 ? 5'(k) : 5'h0b, p == 2 ? 5'(k) : 5'h0b);
        look(3'b111);
        look(3'b000);
      end
    end
    cfg(5'h12, 5'h0e, 5'h0c);
    look(3'b111);
    cfg(5'h0c, 5'h12, 5'h1f);
    look(3'b111);
    cfg(5'h01, 5'h08, 5'h10);
    look(3'b111);
    cfg(5'h0f, 5'h0f, 5'h11);
    look(3'b010);
    wreg(8'h39, 8'he7);
    codes[0] = 5'h07;
    rchk(8'h39, 8'he7);
    look(3'b001);
    wreg(8'h3b, 8'hff);
    rchk(8'h3b, 8'h00);
    rchk(8'h39, 8'he7);
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    codes = '{5'h10, 5'h00, 5'h00};
    rchk(8'h39, 8'h10);
    look(3'b101);
    tally_and_finish();
  end

endmodule // tb_top

`default_nettype wire
